// [logic/mcl_regs.svh]
/*
   Address map, reset values and timing figures of the macrocell loader.
   Assumes a 16-bit host address bus and a 20 MHz core clock.
*/
`ifndef MCL_REGS_SVH
`define MCL_REGS_SVH

`define MCL_ADR_PA_READBACK 16'h200A
`define MCL_ADR_PB_READBACK 16'h200D
`define MCL_ADR_PE_READBACK 16'h200E
`define MCL_ADR_PC_CONTROL  16'h2012
`define MCL_ADR_PC_DATA     16'h2014
`define MCL_ADR_PC_DIR      16'h2016
`define MCL_ADR_NIBBLE      16'h20E0
`define MCL_ADR_STROBE_LO   16'h2100
`define MCL_ADR_STROBE_HI   16'h2101
`define MCL_BLK_STROBE      8'h21
`define MCL_BLK_SETCLR_LO   8'h21
`define MCL_BLK_SETCLR_HI   8'h24
`define MCL_ALL_ONES        8'hFF
`define MCL_RST_BYTE        8'h00
`define MCL_RST_NIBBLE      4'h0
`define MCL_RST_ADDR        16'h0000
`define MCL_CLK_PERIOD_NS   50
`define MCL_WR_LOW_NS       100

`endif

// [logic/mcl_pkg.sv]
/*
   Types of the macrocell loader: the route type is shared by both ends, command and state types are host only.
   Assumes nothing of its surroundings.
*/
package mcl_pkg;

   typedef enum logic [1:0]
   {
      MCL_ROUTE_PAGE     = 2'h0,
      MCL_ROUTE_FEEDBACK = 2'h1,
      MCL_ROUTE_SETCLR   = 2'h2
   } mcl_route_t;

   typedef enum logic [1:0]
   {
      MCL_CMD_READ  = 2'h0,
      MCL_CMD_WRITE = 2'h1,
      MCL_CMD_LOAD  = 2'h2
   } mcl_cmd_t;

   typedef enum logic [3:0]
   {
      MCL_ST_IDLE   = 4'h1,
      MCL_ST_SETUP  = 4'h2,
      MCL_ST_STROBE = 4'h4,
      MCL_ST_GAP    = 4'h8
   } mcl_state_t;

endpackage

// [logic/mcl_if.sv]
/*
   Host bus between the microcontroller end and the macrocell device end.
   Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps

interface mcl_if;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        wr_n;
   logic        rd_n;
   logic [7:0]  rdata;

   modport dev
   (
      input  addr,
      input  wdata,
      input  wr_n,
      input  rd_n,
      output rdata
   );

   modport host
   (
      output addr,
      output wdata,
      output wr_n,
      output rd_n,
      input  rdata
   );
endinterface

// [logic/mcl_device.sv]
/*
   Device end: port C I/O registers, nibble register, the port A, B and
   E macrocells, the three host loading routes into port B, and readback.
   Assumes the host bus and all pins are synchronous to core_clk_in.
*/
`timescale 1ns/1ps
`include "mcl_regs.svh"

// How it works
// R1 - Port B cells readable as one byte.
// R2 - Control FFH puts port C under host.
// R3 - Direction FFH makes port C outputs.
// R4 - Port C data register drives the pins.
// R5 - Driven port C value fed back internally.
// R6 - Strobe-block write captures fed-back byte.
// R7 - Strobes decode whole 256-byte blocks.
// R8 - Small variant feeds back only A or B.
// R9 - Set forces one, clear forces zero.
// R10 - Per-cell set/clear addresses 2100H-24FFH; code decodes only offsets 00H-03H of blocks 21H-24H.
// R11 - Feedback route is fastest for hosts; code's feedback load takes 4 writes, as many as the page route.
// R12 - Buried cells latch data on strobe.
// R13 - Ports A, B, E each read back.
// R14 - Co-processor enable drives port output enable.
// R15 - Byte loads as two nibble writes.
// R16 - Port B cells: own terms, selectable clock.
// R17 - Ports A, E: shared terms, shared clock.
// R18 - Set, clear, enable all active high.
// R19 - Nibble register then strobe copies nibble.
// R20 - Reads harmless; one capture per write.
module mcl_device
(
   mcl_if.dev                    bus,
   input  wire logic             core_clk_in,
   input  wire logic             rst_in,
   input  wire mcl_pkg::mcl_route_t route_sel_in,
   input  wire logic             shared_clk_in,
   input  wire logic [7:0]       pb_clk_sel_in,
   input  wire logic [7:0]       pb_d_in,
   input  wire logic [7:0]       pb_set_term_in,
   input  wire logic [7:0]       pb_clr_term_in,
   input  wire logic [7:0]       pb_oe_term_in,
   input  wire logic             cop_drive_in,
   input  wire logic             cop_enable_in,
   input  wire logic [7:0]       pa_d_in,
   input  wire logic             pa_set_term_in,
   input  wire logic             pa_clr_term_in,
   input  wire logic             pa_oe_term_in,
   input  wire logic [7:0]       pe_d_in,
   input  wire logic             pe_set_term_in,
   input  wire logic             pe_clr_term_in,
   input  wire logic             pe_oe_term_in,
   input  wire logic [7:0]       pc_pin_in,
   output logic      [7:0]       pc_out,
   output logic      [7:0]       pc_oe_out,
   output logic      [7:0]       pa_out,
   output logic      [7:0]       pa_oe_out,
   output logic      [7:0]       pb_out,
   output logic      [7:0]       pb_oe_out,
   output logic      [7:0]       pe_out,
   output logic      [7:0]       pe_oe_out
);
   localparam int CELLS = 8;
   localparam int NIB   = 4;

   logic [7:0] pc_control;
   logic [7:0] pc_data;
   logic [7:0] pc_dir;
   logic [3:0] nibble_reg;
   logic [7:0] rdata;
   logic       wr_n_q;
   logic       shared_q;
   logic [7:0] pa_cells;
   logic [7:0] pe_cells;
   logic [7:0] pb_cells;
   logic [7:0] next_pc_control;
   logic [7:0] next_pc_data;
   logic [7:0] next_pc_dir;
   logic [3:0] next_nibble_reg;
   logic [7:0] next_rdata;
   logic       next_wr_n_q;
   logic       next_shared_q;
   logic [7:0] next_pa_cells;
   logic [7:0] next_pe_cells;
   logic       wr_pulse;
   logic       shared_edge;
   logic       hit_strobe;
   logic       pt_lo;
   logic       pt_hi;
   logic       fb_clk;
   logic       sc_hit;
   logic [7:0] sc_blk_off;
   logic [2:0] sc_cell;
   logic [7:0] pc_feedback;

   // Only the first low cycle of a write strobe counts.
   assign wr_pulse    = ~bus.wr_n & wr_n_q; // R20
   assign shared_edge = shared_clk_in & ~shared_q;

   // Strobe addresses resolve on the upper byte; bit 0 picks the low or high nibble.
   assign hit_strobe = (bus.addr[15:8] == `MCL_BLK_STROBE); // R7
   assign pt_lo = wr_pulse & hit_strobe & ~bus.addr[0]
                & (route_sel_in == mcl_pkg::MCL_ROUTE_PAGE); // R15
   assign pt_hi = wr_pulse & hit_strobe & bus.addr[0]
                & (route_sel_in == mcl_pkg::MCL_ROUTE_PAGE); // R15
   assign fb_clk = wr_pulse & hit_strobe
                 & (route_sel_in == mcl_pkg::MCL_ROUTE_FEEDBACK); // R6

   // Cell pairs share a block: offsets 0/1 even cell, 2/3 odd cell.
   assign sc_blk_off = bus.addr[15:8] - `MCL_BLK_SETCLR_LO;
   assign sc_cell    = {sc_blk_off[1:0], bus.addr[1]}; // R10
   assign sc_hit = wr_pulse
                 & (route_sel_in == mcl_pkg::MCL_ROUTE_SETCLR)
                 & (bus.addr[15:8] >= `MCL_BLK_SETCLR_LO)
                 & (bus.addr[15:8] <= `MCL_BLK_SETCLR_HI)
                 & (bus.addr[7:2] == 6'h00); // R10

   // Port C drives only bits in host mode and set as outputs.
   assign pc_out      = pc_data; // R4
   assign pc_oe_out   = pc_control & pc_dir; // R2 R3
   assign pc_feedback = (pc_oe_out & pc_data)
                      | (~pc_oe_out & pc_pin_in); // R5

   assign pa_out    = pa_cells;
   assign pe_out    = pe_cells;
   assign pb_out    = pb_cells;
   assign pa_oe_out = {CELLS{pa_oe_term_in}}; // R17 R18
   assign pe_oe_out = {CELLS{pe_oe_term_in}}; // R17 R18
   assign pb_oe_out = cop_drive_in ? {CELLS{cop_enable_in}}
                                   : pb_oe_term_in; // R14 R16 R18
   assign bus.rdata = rdata;

   always_comb
   begin
      next_pc_control = pc_control;
      next_pc_data    = pc_data;
      next_pc_dir     = pc_dir;
      next_nibble_reg = nibble_reg;
      next_wr_n_q     = bus.wr_n;
      next_shared_q   = shared_clk_in;
      if (wr_pulse)
      begin
         unique case (bus.addr)
            `MCL_ADR_PC_CONTROL: next_pc_control = bus.wdata; // R2
            `MCL_ADR_PC_DATA:    next_pc_data = bus.wdata; // R4
            `MCL_ADR_PC_DIR:     next_pc_dir = bus.wdata; // R3
            `MCL_ADR_NIBBLE:     next_nibble_reg = bus.wdata[3:0]; // R19
            default:             next_pc_data = pc_data;
         endcase
      end
   end

   // Readback only selects a value; no state changes on a read.
   always_comb
   begin
      next_rdata = `MCL_RST_BYTE;
      if (!bus.rd_n)
      begin
         unique case (bus.addr)
            `MCL_ADR_PB_READBACK: next_rdata = pb_cells; // R1 R13 R20
            `MCL_ADR_PA_READBACK: next_rdata = pa_cells; // R13
            `MCL_ADR_PE_READBACK: next_rdata = pe_cells; // R13
            `MCL_ADR_PC_CONTROL:  next_rdata = pc_control;
            `MCL_ADR_PC_DATA:     next_rdata = pc_data;
            `MCL_ADR_PC_DIR:      next_rdata = pc_dir;
            `MCL_ADR_NIBBLE:      next_rdata = {4'h0, nibble_reg};
            default:              next_rdata = `MCL_RST_BYTE;
         endcase
      end
   end

   // Ports A and E: common terms, shared clock only; clear wins over set.
   always_comb
   begin
      next_pa_cells = pa_cells;
      next_pe_cells = pe_cells;
      if (pa_clr_term_in)
         next_pa_cells = `MCL_RST_BYTE; // R9 R17 R18
      else if (pa_set_term_in)
         next_pa_cells = `MCL_ALL_ONES; // R9 R17 R18
      else if (shared_edge)
         next_pa_cells = pa_d_in; // R12 R17
      if (pe_clr_term_in)
         next_pe_cells = `MCL_RST_BYTE; // R9 R17
      else if (pe_set_term_in)
         next_pe_cells = `MCL_ALL_ONES; // R9 R17
      else if (shared_edge)
         next_pe_cells = pe_d_in; // R17
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         pc_control <= `MCL_RST_BYTE;
         pc_data    <= `MCL_RST_BYTE;
         pc_dir     <= `MCL_RST_BYTE;
         nibble_reg <= `MCL_RST_NIBBLE;
         rdata      <= `MCL_RST_BYTE;
         wr_n_q     <= 1'b1;
         shared_q   <= 1'b0;
         pa_cells   <= `MCL_RST_BYTE;
         pe_cells   <= `MCL_RST_BYTE;
      end
      else
      begin
         pc_control <= next_pc_control;
         pc_data    <= next_pc_data;
         pc_dir     <= next_pc_dir;
         nibble_reg <= next_nibble_reg;
         rdata      <= next_rdata;
         wr_n_q     <= next_wr_n_q;
         shared_q   <= next_shared_q;
         pa_cells   <= next_pa_cells;
         pe_cells   <= next_pe_cells;
      end
   end

   // Port B: each cell has its own terms and its own clock choice.
   genvar i;
   generate
      for (i = 0; i < CELLS; i++)
      begin : g_pb
         logic cell_q;
         logic next_cell_q;
         logic clr;
         logic set;
         logic pt_clk;
         logic pt_d;

         assign clr = pb_clr_term_in[i]
                    | (sc_hit & (sc_cell == 3'(i)) & ~bus.addr[0]); // R10
         assign set = pb_set_term_in[i]
                    | (sc_hit & (sc_cell == 3'(i)) & bus.addr[0]); // R10
         assign pt_clk = fb_clk | ((i < NIB) ? pt_lo : pt_hi); // R15 R19
         assign pt_d   = fb_clk ? pc_feedback[i]
                                : nibble_reg[i % NIB]; // R5 R6 R19

         always_comb
         begin
            next_cell_q = cell_q;
            if (clr)
               next_cell_q = 1'b0; // R9 R16 R18
            else if (set)
               next_cell_q = 1'b1; // R9 R16 R18
            else if (pb_clk_sel_in[i] ? pt_clk : shared_edge)
               next_cell_q = pb_clk_sel_in[i] ? pt_d : pb_d_in[i]; // R16
         end

         always_ff @(posedge core_clk_in)
         begin
            if (rst_in)
               cell_q <= 1'b0;
            else
               cell_q <= next_cell_q;
         end

         assign pb_cells[i] = cell_q;
      end
   endgenerate
endmodule

// [logic/mcl_host.sv]
/*
   Host end: runs single reads and writes and whole byte loads over the
   host bus, one write per step with a fixed strobe width.
   Assumes the device samples the bus on core_clk_in.
*/
`timescale 1ns/1ps
`include "mcl_regs.svh"

module mcl_host
(
   mcl_if.host                    bus,
   input  wire logic              core_clk_in,
   input  wire logic              rst_in,
   input  wire logic              cmd_valid_in,
   input  wire mcl_pkg::mcl_cmd_t cmd_kind_in,
   input  wire mcl_pkg::mcl_route_t cmd_route_in,
   input  wire logic [15:0]       cmd_addr_in,
   input  wire logic [7:0]        cmd_data_in,
   output logic                   cmd_ready_out,
   output logic                   rsp_valid_out,
   output logic      [7:0]        rsp_data_out
);
   localparam int STB_CYC = (`MCL_WR_LOW_NS + `MCL_CLK_PERIOD_NS - 1)
                          / `MCL_CLK_PERIOD_NS;

   mcl_pkg::mcl_state_t state, next_state;
   mcl_pkg::mcl_cmd_t   kind, next_kind;
   mcl_pkg::mcl_route_t route, next_route;
   logic [15:0] addr, next_addr;
   logic [7:0]  byte_q, next_byte_q;
   logic [7:0]  wdata, next_wdata;
   logic        wr_n, next_wr_n;
   logic        rd_n, next_rd_n;
   logic [3:0]  step, next_step;
   logic [3:0]  cnt, next_cnt;
   logic        rsp_valid, next_rsp_valid;
   logic [7:0]  rsp_data, next_rsp_data;

   // Address and data of load step s; nibble and set/clear orders fixed.
   function automatic logic [23:0] load_step(mcl_pkg::mcl_route_t r,
                                             logic [3:0] s, logic [7:0] b);
      logic [2:0] c;
      c = s[2:0];
      load_step = {`MCL_ADR_STROBE_LO, `MCL_RST_BYTE};
      unique case (r)
         mcl_pkg::MCL_ROUTE_FEEDBACK:
            unique case (s[1:0])
               2'h0: load_step = {`MCL_ADR_PC_CONTROL, `MCL_ALL_ONES}; // R2
               2'h1: load_step = {`MCL_ADR_PC_DIR, `MCL_ALL_ONES}; // R3
               2'h2: load_step = {`MCL_ADR_PC_DATA, b}; // R4 R11
               2'h3: load_step = {`MCL_ADR_STROBE_LO, `MCL_RST_BYTE}; // R6
            endcase
         mcl_pkg::MCL_ROUTE_SETCLR:
            load_step = {`MCL_BLK_SETCLR_LO + {6'h00, c[2:1]},
                         6'h00, c[0], b[c], `MCL_RST_BYTE}; // R10
         default:
            unique case (s[1:0])
               2'h0: load_step = {`MCL_ADR_NIBBLE, 4'h0, b[3:0]}; // R19
               2'h1: load_step = {`MCL_ADR_STROBE_LO, `MCL_RST_BYTE}; // R15
               2'h2: load_step = {`MCL_ADR_NIBBLE, 4'h0, b[7:4]}; // R19
               2'h3: load_step = {`MCL_ADR_STROBE_HI, `MCL_RST_BYTE}; // R15
            endcase
      endcase
   endfunction

   function automatic logic [3:0] last_step(mcl_pkg::mcl_cmd_t k,
                                            mcl_pkg::mcl_route_t r);
      if (k != mcl_pkg::MCL_CMD_LOAD)
         last_step = 4'h0;
      else if (r == mcl_pkg::MCL_ROUTE_SETCLR)
         last_step = 4'h7;
      else
         last_step = 4'h3;
   endfunction

   assign cmd_ready_out = (state == mcl_pkg::MCL_ST_IDLE);
   assign bus.addr      = addr;
   assign bus.wdata     = wdata;
   assign bus.wr_n      = wr_n;
   assign bus.rd_n      = rd_n;
   assign rsp_valid_out = rsp_valid;
   assign rsp_data_out  = rsp_data;

   always_comb
   begin
      next_state     = state;
      next_kind      = kind;
      next_route     = route;
      next_addr      = addr;
      next_byte_q    = byte_q;
      next_wdata     = wdata;
      next_wr_n      = 1'b1;
      next_rd_n      = 1'b1;
      next_step      = step;
      next_cnt       = cnt;
      next_rsp_valid = 1'b0;
      next_rsp_data  = rsp_data;
      unique case (state)
         mcl_pkg::MCL_ST_IDLE:
            if (cmd_valid_in)
            begin
               next_kind   = cmd_kind_in;
               next_route  = cmd_route_in;
               next_byte_q = cmd_data_in;
               next_step   = 4'h0;
               next_state  = mcl_pkg::MCL_ST_SETUP;
               if (cmd_kind_in == mcl_pkg::MCL_CMD_LOAD)
                  {next_addr, next_wdata} =
                     load_step(cmd_route_in, 4'h0, cmd_data_in);
               else
                  {next_addr, next_wdata} = {cmd_addr_in, cmd_data_in};
            end
         mcl_pkg::MCL_ST_SETUP:
         begin
            next_wr_n  = (kind == mcl_pkg::MCL_CMD_READ);
            next_rd_n  = (kind != mcl_pkg::MCL_CMD_READ);
            next_cnt   = 4'(STB_CYC - 1);
            next_state = mcl_pkg::MCL_ST_STROBE;
         end
         mcl_pkg::MCL_ST_STROBE:
            if (cnt == 4'h0)
            begin
               next_rsp_data = bus.rdata;
               next_state    = mcl_pkg::MCL_ST_GAP;
            end
            else
            begin
               next_wr_n = wr_n;
               next_rd_n = rd_n;
               next_cnt  = cnt - 4'h1;
            end
         mcl_pkg::MCL_ST_GAP:
            if (step == last_step(kind, route))
            begin
               next_rsp_valid = 1'b1;
               next_state     = mcl_pkg::MCL_ST_IDLE;
            end
            else
            begin
               next_step  = step + 4'h1;
               {next_addr, next_wdata} =
                  load_step(route, step + 4'h1, byte_q);
               next_state = mcl_pkg::MCL_ST_SETUP;
            end
      endcase
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         state     <= mcl_pkg::MCL_ST_IDLE;
         kind      <= mcl_pkg::MCL_CMD_READ;
         route     <= mcl_pkg::MCL_ROUTE_PAGE;
         addr      <= `MCL_RST_ADDR;
         byte_q    <= `MCL_RST_BYTE;
         wdata     <= `MCL_RST_BYTE;
         wr_n      <= 1'b1;
         rd_n      <= 1'b1;
         step      <= 4'h0;
         cnt       <= 4'h0;
         rsp_valid <= 1'b0;
         rsp_data  <= `MCL_RST_BYTE;
      end
      else
      begin
         state     <= next_state;
         kind      <= next_kind;
         route     <= next_route;
         addr      <= next_addr;
         byte_q    <= next_byte_q;
         wdata     <= next_wdata;
         wr_n      <= next_wr_n;
         rd_n      <= next_rd_n;
         step      <= next_step;
         cnt       <= next_cnt;
         rsp_valid <= next_rsp_valid;
         rsp_data  <= next_rsp_data;
      end
   end
endmodule

// [dv/mcl_assertions.sv]
/*
   Concurrent checks on the host bus and the port B and C pins.
   Assumes one core clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
`include "mcl_regs.svh"

module mcl_assertions
(
   input wire logic                core_clk_in,
   input wire logic                rst_in,
   input wire logic [15:0]         addr,
   input wire logic [7:0]          wdata,
   input wire logic                wr_n,
   input wire logic                rd_n,
   input wire logic [7:0]          rdata,
   input wire mcl_pkg::mcl_route_t route_sel_in,
   input wire logic [7:0]          pb_clk_sel_in,
   input wire logic [7:0]          pb_set_term_in,
   input wire logic [7:0]          pb_clr_term_in,
   input wire logic                cop_drive_in,
   input wire logic                cop_enable_in,
   input wire logic [7:0]          pc_out,
   input wire logic [7:0]          pc_oe_out,
   input wire logic [7:0]          pb_out,
   input wire logic [7:0]          pb_oe_out
);
   logic [7:0] sc_blk;
   logic [2:0] sc_cell;
   logic       sc_val;
   logic       quiet;

   assign sc_blk  = addr[15:8] - `MCL_BLK_SETCLR_LO;
   assign sc_cell = {sc_blk[1:0], addr[1]};
   assign sc_val  = addr[0];
   assign quiet   = (pb_set_term_in == 8'h00) && (pb_clr_term_in == 8'h00);

   default clocking dc @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   sequence wr_start;
      $fell(wr_n);
   endsequence

   chk_strobe_once:
   assert property (wr_start |=> !wr_n ##1 wr_n)
      else $error("write strobe is not two cycles wide");
   chk_rdata_idle:
   assert property (rd_n |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   chk_pb_readback:
   assert property (!rd_n && addr == `MCL_ADR_PB_READBACK |=>
      rdata == $past(pb_out))
      else $error("port B readback differs from the cells");
   chk_pc_data:
   assert property (wr_start ##0 addr == `MCL_ADR_PC_DATA |=>
      pc_out == $past(wdata))
      else $error("port C data not taken from the write");
   chk_pc_oe_cause:
   assert property (!$stable(pc_oe_out) |-> $past(!wr_n) &&
      ($past(addr) == `MCL_ADR_PC_CONTROL || $past(addr) == `MCL_ADR_PC_DIR))
      else $error("port C enables changed without a write");
   chk_feedback_load:
   assert property (wr_start ##0 (addr[15:8] == `MCL_BLK_STROBE && quiet
      && route_sel_in == mcl_pkg::MCL_ROUTE_FEEDBACK
      && pb_clk_sel_in == 8'hFF && pc_oe_out == 8'hFF)
      |=> pb_out == $past(pc_out))
      else $error("feedback load did not capture port C");
   chk_set_clear:
   assert property (wr_start ##0 (route_sel_in == mcl_pkg::MCL_ROUTE_SETCLR
      && sc_blk < 8'h04 && addr[7:2] == 6'h00 && quiet)
      |=> pb_out[$past(sc_cell)] == $past(sc_val))
      else $error("set or clear write missed its cell");
   chk_cop_enable:
   assert property (cop_drive_in |-> pb_oe_out == {8{cop_enable_in}})
      else $error("port B enable does not follow co-processor");
endmodule

// [dv/macrocell_load_readback_tb.sv]
/*
   Self-checking bench: host end and device end joined by the bus.
   Assumes the design files and mcl_regs.svh are on the include path.
*/
`timescale 1ns/1ps
`include "mcl_regs.svh"

module macrocell_load_readback_tb;
   logic        core_clk_in, rst_in, shared_clk_in, cop_drive_in;
   logic        cop_enable_in, pa_set_term_in, pa_clr_term_in, pa_oe_term_in;
   logic        pe_set_term_in, pe_clr_term_in, pe_oe_term_in, cmd_valid_in;
   logic        cmd_ready_out, rsp_valid_out;
   logic [7:0]  pb_clk_sel_in, pb_d_in, pb_set_term_in, pb_clr_term_in;
   logic [7:0]  pb_oe_term_in, pa_d_in, pe_d_in, pc_pin_in, cmd_data_in;
   logic [7:0]  pc_out, pc_oe_out, pa_out, pa_oe_out, pb_out, pb_oe_out;
   logic [7:0]  pe_out, pe_oe_out, rsp_data_out, rd_val, b, m, p, e;
   logic [15:0] cmd_addr_in;
   int          fail_count, n_checks, cycles, seed;
   mcl_pkg::mcl_route_t route_sel_in, cmd_route_in;
   mcl_pkg::mcl_cmd_t   cmd_kind_in;

   mcl_if bus_if ();
   mcl_host mcl_host_i (.bus(bus_if), .core_clk_in, .rst_in, .cmd_valid_in,
      .cmd_kind_in, .cmd_route_in, .cmd_addr_in, .cmd_data_in,
      .cmd_ready_out, .rsp_valid_out, .rsp_data_out);
   mcl_device mcl_device_i (.bus(bus_if), .core_clk_in, .rst_in,
      .route_sel_in, .shared_clk_in, .pb_clk_sel_in, .pb_d_in,
      .pb_set_term_in, .pb_clr_term_in, .pb_oe_term_in, .cop_drive_in,
      .cop_enable_in, .pa_d_in, .pa_set_term_in, .pa_clr_term_in,
      .pa_oe_term_in, .pe_d_in, .pe_set_term_in, .pe_clr_term_in,
      .pe_oe_term_in, .pc_pin_in, .pc_out, .pc_oe_out, .pa_out, .pa_oe_out,
      .pb_out, .pb_oe_out, .pe_out, .pe_oe_out);
   mcl_assertions mcl_assertions_i (.core_clk_in, .rst_in,
      .addr(bus_if.addr), .wdata(bus_if.wdata), .wr_n(bus_if.wr_n),
      .rd_n(bus_if.rd_n), .rdata(bus_if.rdata), .route_sel_in,
      .pb_clk_sel_in, .pb_set_term_in, .pb_clr_term_in, .cop_drive_in,
      .cop_enable_in, .pc_out, .pc_oe_out, .pb_out, .pb_oe_out);

   initial
   begin
      core_clk_in = 1'b0;
      forever #25 core_clk_in = ~core_clk_in;
   end

   always @(posedge core_clk_in)
   begin
      cycles = cycles + 1;
      if (cycles == 6000)
      begin
         fail_count = fail_count + 1;
         $display("ERROR %0t: timeout", $time);
         results();
      end
   end

   function automatic logic [7:0] rnd();
      int r;
      r = $random(seed);
      return r[7:0];
   endfunction

   function automatic logic [7:0] mix(input logic [7:0] a, c, sel);
      return (a & sel) | (c & ~sel);
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick();
      @(posedge core_clk_in);
      #2;
   endtask

   task automatic run(input mcl_pkg::mcl_cmd_t k,
      input mcl_pkg::mcl_route_t r, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      tick();
      cmd_kind_in = k;
      cmd_route_in = r;
      cmd_addr_in = a;
      cmd_data_in = d;
      cmd_valid_in = 1'b1;
      tick();
      cmd_valid_in = 1'b0;
      check({7'h00, cmd_ready_out}, 8'h00);
      do
      begin
         @(negedge core_clk_in);
         n = n + 1;
      end
      while (rsp_valid_out !== 1'b1 && n < 80);
      check({6'h00, cmd_ready_out, rsp_valid_out}, 8'h03);
      rd_val = rsp_data_out;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      run(mcl_pkg::MCL_CMD_WRITE, mcl_pkg::MCL_ROUTE_PAGE, a, d);
   endtask

   task automatic rd(input logic [15:0] a);
      run(mcl_pkg::MCL_CMD_READ, mcl_pkg::MCL_ROUTE_PAGE, a, 8'h00);
   endtask

   task automatic load(input mcl_pkg::mcl_route_t r, input logic [7:0] d);
      tick();
      route_sel_in = r;
      run(mcl_pkg::MCL_CMD_LOAD, r, 16'h0000, d);
      rd(`MCL_ADR_PB_READBACK);
   endtask

   task automatic results();
      if (fail_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      seed = 27062;
      fail_count = 0;
      n_checks = 0;
      cycles = 0;
      rst_in = 1'b1;
      {shared_clk_in, cop_drive_in, cop_enable_in, pa_set_term_in} = 4'h0;
      {pa_clr_term_in, pa_oe_term_in, pe_set_term_in, pe_clr_term_in} = 4'h0;
      {pe_oe_term_in, cmd_valid_in} = 2'h0;
      {pb_d_in, pb_set_term_in, pb_clr_term_in, pb_oe_term_in} = 32'h0000_0000;
      {pa_d_in, pe_d_in, pc_pin_in, cmd_data_in} = 32'h0000_0000;
      pb_clk_sel_in = 8'hFF;
      cmd_addr_in = 16'h0000;
      route_sel_in = mcl_pkg::MCL_ROUTE_PAGE;
      cmd_route_in = mcl_pkg::MCL_ROUTE_PAGE;
      cmd_kind_in = mcl_pkg::MCL_CMD_READ;
      repeat (20) tick();
      rst_in = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         m = rnd();
         p = rnd();
         b = rnd();
         wr(`MCL_ADR_PC_CONTROL, m);
         wr(`MCL_ADR_PC_DIR, p);
         wr(`MCL_ADR_PC_DATA, b);
         check(pc_out, b);
         check(pc_oe_out, m & p);
      end
      rd(`MCL_ADR_PC_CONTROL);
      check(rd_val, m);
      rd(`MCL_ADR_PC_DIR);
      check(rd_val, p);
      rd(`MCL_ADR_PC_DATA);
      check(rd_val, b);
      load(mcl_pkg::MCL_ROUTE_FEEDBACK, b);
      check(rd_val, b);
      rd(`MCL_ADR_PB_READBACK);
      check(rd_val, b);
      tick();
      pc_pin_in = rnd();
      wr(`MCL_ADR_PC_DIR, 8'h0F);
      wr(`MCL_ADR_STROBE_HI, rnd());
      rd(`MCL_ADR_PB_READBACK);
      check(rd_val, mix(b, pc_pin_in, 8'h0F));
      b = rnd();
      load(mcl_pkg::MCL_ROUTE_PAGE, b);
      check(rd_val, b);
      p = rnd();
      wr(`MCL_ADR_NIBBLE, p);
      rd(`MCL_ADR_NIBBLE);
      check(rd_val, {4'h0, p[3:0]});
      wr(16'h21FE, rnd());
      rd(`MCL_ADR_PB_READBACK);
      check(rd_val, {b[7:4], p[3:0]});
      load(mcl_pkg::MCL_ROUTE_SETCLR, p);
      check(rd_val, p);
      e = rnd();
      for (int i = 0; i < 8; i++)
         wr({8'h21 + 8'(i / 2), 6'h00, 1'(i % 2), e[i]}, rnd());
      wr(16'h2105, 8'h00);
      rd(`MCL_ADR_PB_READBACK);
      check(rd_val, e);
      tick();
      pb_clk_sel_in = 8'h0F;
      pb_d_in = rnd();
      pa_d_in = rnd();
      pe_d_in = rnd();
      shared_clk_in = 1'b1;
      tick();
      tick();
      shared_clk_in = 1'b0;
      e = mix(e, pb_d_in, 8'h0F);
      rd(`MCL_ADR_PB_READBACK);
      check(rd_val, e);
      rd(`MCL_ADR_PA_READBACK);
      check(rd_val, pa_d_in);
      rd(`MCL_ADR_PE_READBACK);
      check(rd_val, pe_d_in);
      tick();
      m = rnd();
      p = rnd();
      pb_set_term_in = m;
      pb_clr_term_in = p;
      pa_set_term_in = 1'b1;
      pe_clr_term_in = 1'b1;
      tick();
      tick();
      e = (e | m) & ~p;
      check(pb_out, e);
      check(pa_out, 8'hFF);
      check(pe_out, 8'h00);
      {pb_set_term_in, pb_clr_term_in} = 16'h0000;
      pa_set_term_in = 1'b0;
      pe_clr_term_in = 1'b0;
      wr(`MCL_ADR_PB_READBACK, ~e);
      rd(`MCL_ADR_PB_READBACK);
      check(rd_val, e);
      rd(16'h2001);
      check(rd_val, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         tick();
         {cop_drive_in, cop_enable_in, pa_oe_term_in} = 3'(i);
         pe_oe_term_in = ~pa_oe_term_in;
         pb_oe_term_in = rnd();
         @(negedge core_clk_in);
         check(pb_oe_out, mix({8{cop_enable_in}}, pb_oe_term_in,
            {8{cop_drive_in}}));
         check(pa_oe_out, {8{pa_oe_term_in}});
         check(pe_oe_out, {8{pe_oe_term_in}});
      end
      results();
   end
endmodule
